//--- hdl/ecbc_eeprom_ctrl.sv
/*
 * EEPROM command and busy controller: command and data registers, a
 * serial sequencer, write-done polling with time-out, and the station
 * address load after reset.
 * Assumes a synchronous register port and an EEPROM input already
 * synchronous to sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module ecbc_eeprom_ctrl #(
   parameter int TIMEOUT_CYCLES = ecbc_pkg::TIMEOUT_CYC
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic eeCs,
   output logic eeClk,
   output logic eeDo,
   input wire logic eeDi,
   output logic [47:0] macAddr,
   output logic macAddrValid
);
   import ecbc_pkg::*;

   ecbc_state_t state, next_state; // Sequencer state
   logic busy, next_busy; // Busy flag seen by software
   logic [2:0] opSel, next_opSel; // Selected operation
   logic [7:0] eeAddr, next_eeAddr; // EEPROM byte address
   logic [7:0] dataReg, next_dataReg; // Data register
   logic timeoutFlag, next_timeoutFlag; // Sticky time-out flag
   logic [18:0] shOut, next_shOut; // Outgoing frame, MSB first
   logic [7:0] rxData, next_rxData; // Incoming bits
   logic [4:0] bitCnt, next_bitCnt; // Bits left in the phase
   logic phase, next_phase; // Serial clock level
   logic csOn, next_csOn; // Chip select level
   logic isWrite, next_isWrite; // Current op is a write
   logic autoMode, next_autoMode; // Station address load running
   logic [2:0] autoIdx, next_autoIdx; // Byte index in the load
   logic [31:0] toCnt, next_toCnt; // Time-out counter
   logic [47:0] next_macAddr;
   logic next_macAddrValid;
   logic [31:0] next_regRdata;
   logic tick; // Half-bit enable
   logic cmdWr; // Write to the command register
   logic [7:0] rxByte; // Byte complete on the last sample

   assign cmdWr = regWr && (regAddr == CMD_OFFSET);
   assign rxByte = rxData;
   assign eeCs = csOn;
   assign eeClk = phase;
   assign eeDo = shOut[18];

   // Half-bit timing runs whenever the sequencer is out of ST_IDLE
   ecbc_tick_div #(.HALF_CYC(EE_HALF_CYC)) u_div (
      .sys_clk(sys_clk),
      .srst(srst),
      .run(state != ST_IDLE),
      .tick(tick)
   );

   // Next-state logic for registers and sequencer
   always_comb begin
      next_state = state;
      next_busy = busy;
      next_opSel = opSel;
      next_eeAddr = eeAddr;
      next_dataReg = dataReg;
      next_timeoutFlag = timeoutFlag;
      next_shOut = shOut;
      next_rxData = rxData;
      next_bitCnt = bitCnt;
      next_phase = phase;
      next_csOn = csOn;
      next_isWrite = isWrite;
      next_autoMode = autoMode;
      next_autoIdx = autoIdx;
      next_toCnt = toCnt;
      next_macAddr = macAddr;
      next_macAddrValid = macAddrValid;
      next_regRdata = 32'h0000_0000;

      // Read data only in the cycle after the strobe
      if (regRd) begin
         if (regAddr == CMD_OFFSET) begin
            next_regRdata[BUSY_BIT] = busy;
            next_regRdata[OPSEL_LSB +: 3] = opSel;
            next_regRdata[TIMEOUT_BIT] = timeoutFlag;
            next_regRdata[MAC_OK_BIT] = macAddrValid;
            next_regRdata[ADDR_LSB +: 8] = eeAddr;
         end else if (regAddr == DATA_OFFSET) begin
            next_regRdata[7:0] = dataReg;
         end
      end

      // Data writes while busy are dropped; software must wait anyway
      if (regWr && (regAddr == DATA_OFFSET) && !busy) begin
         next_dataReg = regWdata[7:0];
      end
      if (cmdWr) begin
         // Write one clears the time-out flag; a new time-out below wins
         if (regWdata[TIMEOUT_BIT]) begin
            next_timeoutFlag = 1'b0;
         end
         if (!busy) begin
            next_opSel = regWdata[OPSEL_LSB +: 3];
            next_eeAddr = regWdata[ADDR_LSB +: 8];
            // Unknown codes are accepted but start nothing
            if (regWdata[BUSY_BIT] && (regWdata[OPSEL_LSB +: 3] == OP_READ)) begin
               next_busy = 1'b1;
               next_state = ST_SEND;
               next_isWrite = 1'b0;
               next_csOn = 1'b1;
               next_bitCnt = RD_SEND_BITS;
               next_shOut = {1'b1, EE_RD_OPC, regWdata[ADDR_LSB +: 8], 8'h00};
            end else if (regWdata[BUSY_BIT] && (regWdata[OPSEL_LSB +: 3] == OP_WRITE)) begin
               next_busy = 1'b1;
               next_state = ST_SEND;
               next_isWrite = 1'b1;
               next_csOn = 1'b1;
               next_bitCnt = WR_SEND_BITS;
               next_shOut = {1'b1, EE_WR_OPC, regWdata[ADDR_LSB +: 8], dataReg};
            end
         end
      end

      case (state)
         ST_IDLE: begin
            next_phase = 1'b0;
         end
         // Shift the frame out, data changes while the clock is low
         ST_SEND: begin
            if (tick) begin
               next_phase = !phase;
               if (phase) begin
                  next_shOut = {shOut[17:0], 1'b0};
                  next_bitCnt = bitCnt - 5'h01;
                  if (bitCnt == 5'h01) begin
                     next_bitCnt = RECV_BITS;
                     next_state = isWrite ? ST_GAP : ST_RECV;
                     next_csOn = !isWrite;
                  end
               end
            end
         end
         // Sample on the rising serial clock
         ST_RECV: begin
            if (tick) begin
               next_phase = !phase;
               if (!phase) begin
                  next_rxData = {rxData[6:0], eeDi};
               end else begin
                  next_bitCnt = bitCnt - 5'h01;
                  if (bitCnt == 5'h01) begin
                     next_csOn = 1'b0;
                     next_state = ST_IDLE;
                     next_busy = 1'b0;
                     if (!autoMode) begin
                        next_dataReg = rxByte;
                     end else if ((autoIdx == 3'h0) && (rxByte != MAC_SIG)) begin
                        next_autoMode = 1'b0;
                     end else begin
                        // Load each byte after the signature, then fetch the next one until byte 6
                        if (autoIdx != 3'h0) begin
                           next_macAddr[8 * (int'(autoIdx) - 1) +: 8] = rxByte;
                        end
                        if (autoIdx == MAC_BYTES) begin
                           next_autoMode = 1'b0;
                           next_macAddrValid = 1'b1;
                        end else begin
                           next_autoIdx = autoIdx + 3'h1;
                           next_busy = 1'b1;
                           // Deselect for a half bit so the part sees a fresh frame
                           next_state = ST_GAP;
                           next_bitCnt = RD_SEND_BITS;
                           next_shOut = {1'b1, EE_RD_OPC, 5'h00, autoIdx + 3'h1, 8'h00};
                        end
                     end
                  end
               end
            end
         end
         // Chip select low for one half bit, then poll or send the next read
         ST_GAP: begin
            if (tick) begin
               next_csOn = 1'b1;
               next_toCnt = 32'h0000_0000;
               next_state = isWrite ? ST_POLL : ST_SEND;
            end
         end
         // Ready shows as a high input; an absent part never answers
         ST_POLL: begin
            next_toCnt = toCnt + 32'h0000_0001;
            if (eeDi) begin
               next_csOn = 1'b0;
               next_busy = 1'b0;
               next_state = ST_IDLE;
            end else if (toCnt == 32'(TIMEOUT_CYCLES - 1)) begin
               next_csOn = 1'b0;
               next_busy = 1'b0;
               next_timeoutFlag = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Registers; reset launches the station address read at byte zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state <= ST_SEND;
         busy <= 1'b1;
         opSel <= OP_READ;
         eeAddr <= 8'h00;
         dataReg <= 8'h00;
         timeoutFlag <= 1'b0;
         shOut <= {1'b1, EE_RD_OPC, 8'h00, 8'h00};
         rxData <= 8'h00;
         bitCnt <= RD_SEND_BITS;
         phase <= 1'b0;
         csOn <= 1'b1;
         isWrite <= 1'b0;
         autoMode <= 1'b1;
         autoIdx <= 3'h0;
         toCnt <= 32'h0000_0000;
         macAddr <= 48'h0000_0000_0000;
         macAddrValid <= 1'b0;
         regRdata <= 32'h0000_0000;
      end else begin
         state <= next_state;
         busy <= next_busy;
         opSel <= next_opSel;
         eeAddr <= next_eeAddr;
         dataReg <= next_dataReg;
         timeoutFlag <= next_timeoutFlag;
         shOut <= next_shOut;
         rxData <= next_rxData;
         bitCnt <= next_bitCnt;
         phase <= next_phase;
         csOn <= next_csOn;
         isWrite <= next_isWrite;
         autoMode <= next_autoMode;
         autoIdx <= next_autoIdx;
         toCnt <= next_toCnt;
         macAddr <= next_macAddr;
         macAddrValid <= next_macAddrValid;
         regRdata <= next_regRdata;
      end
   end

   // Checks beside the logic
   a_start_busy: assert property (@(posedge sys_clk) disable iff (srst)
      cmdWr && !busy && regWdata[BUSY_BIT] && (regWdata[OPSEL_LSB +: 3] == OP_WRITE)
      |=> busy && eeCs && (state == ST_SEND) && isWrite)
      else $error("write command did not start");
   a_busy_clear_cause: assert property (@(posedge sys_clk) disable iff (srst)
      $fell(busy) |-> ($past(state) == ST_RECV) || ($past(state) == ST_POLL))
      else $error("busy cleared before completion");
   a_read_data: assert property (@(posedge sys_clk) disable iff (srst)
      $fell(busy) && $past(state == ST_RECV && !autoMode) |-> dataReg == $past(rxData))
      else $error("read data not in data register");
   a_busy_cmd_kept: assert property (@(posedge sys_clk) disable iff (srst)
      busy && cmdWr |=> $stable(opSel) && $stable(eeAddr))
      else $error("command changed while busy");
   a_timeout_end: assert property (@(posedge sys_clk) disable iff (srst)
      (state == ST_POLL) && !eeDi && (toCnt == 32'(TIMEOUT_CYCLES - 1))
      |=> !busy && timeoutFlag && (state == ST_IDLE))
      else $error("time-out did not clear busy");
   a_reset_busy: assert property (@(posedge sys_clk)
      $past(srst) && !srst |-> busy && autoMode && (state == ST_SEND))
      else $error("busy not set after reset");
   a_auto_busy: assert property (@(posedge sys_clk) disable iff (srst)
      autoMode |-> busy)
      else $error("busy low during address load");
   a_rdata_idle: assert property (@(posedge sys_clk) disable iff (srst)
      !$past(regRd) |-> regRdata == 32'h0000_0000)
      else $error("read data outside read slot");

   c_read_done: cover property (@(posedge sys_clk) disable iff (srst)
      $fell(busy) && $past(state == ST_RECV && !autoMode));
   c_write_done: cover property (@(posedge sys_clk) disable iff (srst)
      (state == ST_POLL) && eeDi);
   c_timeout: cover property (@(posedge sys_clk) disable iff (srst) $rose(timeoutFlag));
   c_mac_loaded: cover property (@(posedge sys_clk) disable iff (srst) $rose(macAddrValid));
endmodule
`default_nettype wire

//--- hdl/ecbc_pkg.sv
/*
 * Constants shared by the EEPROM command and busy controller: register
 * offsets, field positions, serial frame sizes, opcodes and timing.
 * Assumes a 50 MHz system clock and a three-wire serial EEPROM.
 */
package ecbc_pkg;

   // Register offsets on the plain register port
   localparam logic [7:0] CMD_OFFSET = 8'hb0;
   localparam logic [7:0] DATA_OFFSET = 8'hb4;

   // Field positions in the command register
   localparam int BUSY_BIT = 31;
   localparam int OPSEL_LSB = 28;
   localparam int TIMEOUT_BIT = 9;
   localparam int MAC_OK_BIT = 8;
   localparam int ADDR_LSB = 0;

   // Operation select codes
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h3;

   // Serial opcodes sent after the start bit
   localparam logic [1:0] EE_RD_OPC = 2'h2;
   localparam logic [1:0] EE_WR_OPC = 2'h1;

   // Frame lengths in serial bits
   localparam logic [4:0] RD_SEND_BITS = 5'h0b;
   localparam logic [4:0] WR_SEND_BITS = 5'h13;
   localparam logic [4:0] RECV_BITS = 5'h08;

   // Station address image in the EEPROM
   localparam logic [7:0] MAC_SIG = 8'ha5;
   localparam logic [2:0] MAC_BYTES = 3'h6;

   // Timing
   localparam int CLK_MHZ = 50;
   localparam int EE_HALF_NS = 1000;
   localparam int EE_HALF_CYC = (EE_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int TIMEOUT_US = 30000;
   localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;

   // Sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_SEND, ST_RECV, ST_GAP, ST_POLL} ecbc_state_t;

endpackage

//--- hdl/ecbc_tick_div.sv
/*
 * Divider giving one-cycle tick pulses at the serial half-bit rate.
 * Assumes run stays high for the whole of a serial operation.
 */
`timescale 1ns/10ps
`default_nettype none
module ecbc_tick_div #(
   parameter int HALF_CYC = ecbc_pkg::EE_HALF_CYC
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic run,
   output logic tick
);
   import ecbc_pkg::*;

   logic [15:0] count; // Cycles since last tick
   logic [15:0] next_count;

   // Restart from zero when idle, so each frame starts with a full half bit
   always_comb begin
      next_count = count + 16'h0001;
      tick = 1'b0;
      if (!run) begin
         next_count = 16'h0000;
      end else if (count == 16'(HALF_CYC - 1)) begin
         next_count = 16'h0000;
         tick = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         count <= 16'h0000;
      end else begin
         count <= next_count;
      end
   end
endmodule
`default_nettype wire

//--- verification/ecbc_eeprom_ctrl_bench.sv
/*
 * Self-checking bench for the EEPROM command and busy controller.
 * Assumes the serial model ecbc_eeprom_model and a shortened time-out.
 */
`timescale 1ns/10ps
`default_nettype none
module ecbc_eeprom_ctrl_bench;
   import ecbc_pkg::*;
   localparam int TMO = 400; // Short time-out, still above the model's write time
   logic sys_clk, srst, regWr, regRd, eeCs, eeClk, eeDo, eeDi, macAddrValid, present;
   logic [7:0] regAddr;
   logic [31:0] regWdata, regRdata, rd;
   logic [47:0] macAddr;
   int errorCnt, nCompared;
   int cycles = 0; // Hang guard count

   ecbc_eeprom_ctrl #(.TIMEOUT_CYCLES(TMO)) DUT (.sys_clk(sys_clk), .srst(srst),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .eeCs(eeCs), .eeClk(eeClk), .eeDo(eeDo), .eeDi(eeDi),
      .macAddr(macAddr), .macAddrValid(macAddrValid));
   ecbc_eeprom_model #(.WR_CYC(300)) farEnd (.sys_clk(sys_clk), .present(present),
      .eeCs(eeCs), .eeClk(eeClk), .eeDo(eeDo), .eeDi(eeDi));

   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Expected EEPROM contents, same image the model starts with
   function automatic logic [7:0] eeByte(input int a);
      return (a == 0) ? 8'ha5 : 8'(a) ^ 8'h5a;
   endfunction

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errorCnt++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One-cycle strobes, launched just after an edge
   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic regRead(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask

   // Only the command word is read until busy clears
   task automatic waitIdle(output int n, output logic [31:0] d);
      n = 0;
      do begin
         regRead(CMD_OFFSET, d);
         n += 2;
      end while (d[BUSY_BIT] === 1'b1 && n < 20000);
   endtask

   // Busy right after reset, then the station address load ends it
   task automatic tResetLoad(input logic ok);
      int n;
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      regRead(CMD_OFFSET, rd);
      check(rd[BUSY_BIT], 1'b1);
      waitIdle(n, rd);
      check(rd[BUSY_BIT], 1'b0);
      check(rd[MAC_OK_BIT], ok);
      check(macAddrValid, ok);
      if (ok) begin // Byte 1 lands lowest
         check(macAddr, {eeByte(6), eeByte(5), eeByte(4), eeByte(3), eeByte(2), eeByte(1)});
      end
      $display("test reset load done");
   endtask

   // Read op: busy over the whole frame, data ready once it clears
   task automatic tRead(input logic [7:0] a, input logic [7:0] e);
      int n;
      regWrite(CMD_OFFSET, {1'b1, OP_READ, 20'h0, a});
      regRead(CMD_OFFSET, rd);
      check(rd[BUSY_BIT], 1'b1);
      check(rd[7:0], a);
      waitIdle(n, rd);
      check(n > 1800, 1'b1);
      regRead(DATA_OFFSET, rd);
      check(rd, {24'h0, e});
      $display("test read done");
   endtask

   // Write op, with the part present or missing
   task automatic tWrite(input logic [7:0] a, input logic [7:0] v, input logic here);
      int n;
      regWrite(DATA_OFFSET, {24'h0, v});
      regWrite(CMD_OFFSET, {1'b1, OP_WRITE, 20'h0, a});
      // Host breaks the rule on purpose; the design must drop both writes
      regWrite(DATA_OFFSET, {24'h0, ~v});
      regWrite(CMD_OFFSET, {1'b1, OP_READ, 20'h0, ~a});
      waitIdle(n, rd);
      check(n > (here ? 2200 : 2300), 1'b1);
      check(rd[TIMEOUT_BIT], !here);
      check(rd[7:0], a);
      check(rd[30:28], OP_WRITE);
      regRead(DATA_OFFSET, rd);
      check(rd, {24'h0, v});
      if (!here) begin // Flag clears by writing one, no start
         regWrite(CMD_OFFSET, {22'h0, 1'b1, 9'h0});
         regRead(CMD_OFFSET, rd);
         check(rd[TIMEOUT_BIT], 1'b0);
         check(rd[BUSY_BIT], 1'b0);
      end
      $display("test write done");
   endtask

   // Main sequence
   initial begin
      srst = 1'b1;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWdata = 32'h0;
      present = 1'b1;
      errorCnt = 0;
      nCompared = 0;
      tResetLoad(1'b1);
      tRead(8'h05, eeByte(5));
      tRead(8'hff, eeByte(255));
      tWrite(8'h10, 8'hc3, 1'b1);
      tRead(8'h10, 8'hc3);
      @(posedge sys_clk);
      present <= 1'b0;
      tWrite(8'h20, 8'h3c, 1'b0);
      tResetLoad(1'b0);
      present <= 1'b1;
      regRead(8'h40, rd);
      check(rd, 48'h0); // Unmapped reads zero
      report_and_stop();
   end

   // Hang guard, well above the roughly 30k cycles needed
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errorCnt++;
         report_and_stop();
      end
   end
endmodule
`default_nettype wire

//--- verification/ecbc_eeprom_model.sv
/*
 * Behavioural three-wire serial EEPROM facing the command controller.
 * Assumes the controller's serial outputs change only on sys_clk edges
 * and that the data-out line has a pull-down when nobody drives it.
 */
`timescale 1ns/10ps
`default_nettype none
module ecbc_eeprom_model #(
   parameter int WR_CYC = 300
) (
   input wire logic sys_clk,
   input wire logic present,
   input wire logic eeCs,
   input wire logic eeClk,
   input wire logic eeDo,
   output logic eeDi
);
   logic [7:0] mem [256]; // Storage array
   logic [18:0] sh; // Incoming bit shifter
   logic [1:0] op; // Captured opcode
   logic [7:0] addr; // Captured address
   logic csQ, clkQ; // Previous line levels
   logic wrPend, polling; // Internal write in progress
   int cnt, left; // Bits seen, write time left

   // Known contents, signature at byte zero
   initial begin
      for (int a = 0; a < 256; a++) begin
         mem[a] = (a == 0) ? 8'ha5 : 8'(a) ^ 8'h5a;
      end
      eeDi = 1'b0;
      wrPend = 1'b0;
      polling = 1'b0;
      cnt = 0;
   end

   // Edge detection on the serial lines, sampled on the system clock
   always @(posedge sys_clk) begin
      csQ <= eeCs;
      clkQ <= eeClk;
      if (eeCs && !csQ) begin // Frame start; a pending write turns into a poll
         cnt = 0;
         polling = wrPend;
         wrPend = 1'b0;
         left = WR_CYC;
      end
      if (!eeCs && csQ) begin // Frame end; only a whole write frame is stored
         wrPend = !polling && cnt == 19 && op == 2'h1;
         if (wrPend && present) begin
            mem[addr] = sh[7:0];
         end
         polling = 1'b0;
         eeDi <= 1'b0;
      end
      if (eeCs && eeClk && !clkQ) begin // Rising serial clock shifts in
         sh = {sh[17:0], eeDo};
         cnt++;
         if (cnt == 3) begin
            op = sh[1:0];
         end
         if (cnt == 11) begin
            addr = sh[7:0];
         end
      end
      if (eeCs && !eeClk && clkQ) begin // Falling edge drives out, MSB first
         eeDi <= (present && op == 2'h2 && cnt >= 11 && cnt < 19) ? mem[addr][18 - cnt] : 1'b0;
      end
      if (polling) begin // Absent part never signals ready
         if (left > 0) begin
            left--;
         end
         eeDi <= present && left == 0;
      end
   end
endmodule
`default_nettype wire
